// *** logic/fault_diag_consts.vh ***
// constants for the controller fault diagnostics block
`ifndef FAULT_DIAG_CONSTS_VH
`define FAULT_DIAG_CONSTS_VH

// register byte offsets
`define REG_CONTROL        8'h00
`define REG_STATUS         8'h04
`define REG_HEALTH         8'h08
`define REG_FAULT_SOURCE   8'h0C
`define REG_HALT_CAUSE     8'h10
`define REG_ADDR_LOW       8'h14
`define REG_ADDR_HIGH      8'h18
`define REG_CHAN_SELECT    8'h1C
`define REG_CHAN_DIAG      8'h20

// control register bit positions
`define CTL_COLD_INIT      0
`define CTL_RUN            1
`define CTL_HALT_ON_FAULT  2
`define CTL_STOP_MODE      3
`define CTL_CLEAR_FLAGS    4

// status register bit positions
`define ST_RUNNING         0
`define ST_HALTED          1
`define ST_ERROR           2
`define ST_STRING          3
`define ST_ARITH           4
`define ST_INDEX           5
`define ST_STOPPED         6

// halt cause codes
`define CAUSE_HALT_INSTR   16'h2258
`define CAUSE_FLOW         16'h2259
`define CAUSE_CALL_BASE    16'h2300
`define CAUSE_CHART_LOW    8'hF4
`define CAUSE_CHART_FIRST  8'h81
`define CAUSE_CHART_LAST   8'h95
`define CAUSE_CHECKSUM     16'h9690
`define CAUSE_WATCHDOG     16'hDEB0
`define CAUSE_FRACTION     16'hDE87
`define CAUSE_DIV_ZERO     16'hDEF0
`define CAUSE_STRING       16'hDEF1
`define CAUSE_CAPACITY     16'hDEF2
`define CAUSE_INDEX        16'hDEF3

// system fault source codes
`define SRC_WATCHDOG_BUS   16'h0080
`define SRC_BUS_WIRING     16'h0081
`define SRC_STACK_INT      16'h0090

// fault kind encoding on the program fault port
`define KIND_NONE          4'h0
`define KIND_HALT_INSTR    4'h1
`define KIND_FLOW          4'h2
`define KIND_CALL          4'h3
`define KIND_UNKNOWN_FN    4'h4
`define KIND_CHART         4'h5
`define KIND_CHECKSUM      4'h6
`define KIND_WATCHDOG      4'h7
`define KIND_FRACTION      4'h8
`define KIND_DIV_ZERO      4'h9
`define KIND_STRING        4'hA
`define KIND_CAPACITY      4'hB
`define KIND_INDEX         4'hC
`define KIND_FLOAT         4'hD

// system fault kinds
`define SYS_WATCHDOG       2'h0
`define SYS_BUS_WIRING     2'h1
`define SYS_STACK_INT      2'h2

`define AXI_OKAY           2'h0
`define AXI_SLVERR         2'h2

`endif

// *** logic/controller_fault_diagnostics.v ***
// fault classification, halt capture and status registers over AXI4-Lite
// Contract
// RQ1: blocking fault halts program, no system error
// RQ2: halt stores cause code, lights error lamp
// RQ3: halt captures faulting instruction address words
// RQ4: halt 2258, flow 2259, 23xx, 0xxx
// RQ5: chart faults coded 81F4 through 95F4
// RQ6: checksum fault 9690, watchdog overrun DEB0
// RQ7: arithmetic codes DE87, DEF0 to DEF3
// RQ8: halted device needs init; cold init bit
// RQ9: init restores data, stops tasks, fallback outputs
// RQ10: after init resume only on run command
// RQ11: recoverable faults reported, state kept running
// RQ12: module fault clears health bit, lamp on
// RQ13: task fault clears task health bit
// RQ14: eight rack health bits, cleared per rack
// RQ15: channel fault bit and type word set
// RQ16: string fault sets string fault bit
// RQ17: overrun, float, divide zero set arith bit
// RQ18: index fault bit set, cause word updated
// RQ19: halt-on-fault bit makes recoverable faults blocking
// RQ20: system fault forces error, cold restart only; code ignores it in stop mode while stopped
// RQ21: system fault source codes 80h, 81h, 90h
// RQ22: captured words held until next initialization
`timescale 1ns/100ps
`default_nettype none
`include "fault_diag_consts.vh"

module controller_fault_diagnostics #(
  parameter CHANNELS = 16,                   // diagnosable i/o channels
  parameter CHAN_W   = 4                     // channel index width
) (
  input  wire                ref_clk,        // controller clock
  input  wire                reset_n,        // async reset, active low
  // AXI4-Lite slave
  input  wire [7:0]          s_axi_awaddr,   // write address
  input  wire                s_axi_awvalid,  // write address valid
  output reg                 s_axi_awready,  // write address ready
  input  wire [31:0]         s_axi_wdata,    // write data
  input  wire [3:0]          s_axi_wstrb,    // write strobes
  input  wire                s_axi_wvalid,   // write data valid
  output reg                 s_axi_wready,   // write data ready
  output reg  [1:0]          s_axi_bresp,    // write response
  output reg                 s_axi_bvalid,   // write response valid
  input  wire                s_axi_bready,   // write response ready
  input  wire [7:0]          s_axi_araddr,   // read address
  input  wire                s_axi_arvalid,  // read address valid
  output reg                 s_axi_arready,  // read address ready
  output reg  [31:0]         s_axi_rdata,    // read data
  output reg  [1:0]          s_axi_rresp,    // read response
  output reg                 s_axi_rvalid,   // read data valid
  input  wire                s_axi_rready,   // read data ready
  // program engine fault reporting, same clock
  input  wire                progFault,      // one-cycle fault strobe
  input  wire [3:0]          progFaultKind,  // fault kind code
  input  wire [7:0]          progFaultArg,   // chart index or low byte
  input  wire [31:0]         instrAddr,      // address of executing instr
  // system fault reporting, same clock
  input  wire                sysFault,       // one-cycle system fault strobe
  input  wire [1:0]          sysFaultKind,   // system fault kind
  // rack i/o fault reporting, same clock
  input  wire                ioFault,        // one-cycle i/o fault strobe
  input  wire [2:0]          ioFaultRack,    // rack address 0..7
  input  wire                ioFaultInTask,  // fault seen in running task
  input  wire [CHAN_W-1:0]   ioFaultChan,    // faulty channel
  input  wire [15:0]         ioFaultType,    // module specific fault type
  // outputs to the cpu
  output reg                 runEnable,      // program execution allowed
  output reg                 initPulse,      // one-cycle init to tasks/data
  output reg                 outputsFallback,// outputs in fallback position
  output reg                 inputRefresh,   // one-cycle input image refresh
  output reg                 errLamp,        // error lamp
  output reg                 ioLamp,         // cpu i/o lamp steady
  output reg                 moduleIoHealthN,// module i/o health, low = fault
  output reg                 taskIoHealthN   // task i/o health, low = fault
);

  // ==========================================================
  // state machine
  localparam [3:0] ST_STOP = 4'b0001;
  localparam [3:0] ST_RUN  = 4'b0010;
  localparam [3:0] ST_HALT = 4'b0100;
  localparam [3:0] ST_ERR  = 4'b1000;

  reg  [3:0]          state;
  reg  [3:0]          next_state;
  reg  [15:0]         haltCause;
  reg  [15:0]         faultSource;
  reg  [31:0]         faultAddr;
  reg                 stringFault;
  reg                 arithFault;
  reg                 indexFault;
  reg                 haltOnFault;
  reg                 stopMode;
  reg  [7:0]          rackHealthN;
  reg  [CHANNELS-1:0] chanFault;
  reg  [15:0]         chanType [0:CHANNELS-1];
  reg  [CHAN_W-1:0]   chanSel;
  reg                 coldInitReq;
  reg                 runReq;
  reg                 clearReq;

  // cause code for the reported kind, plus blocking class
  reg  [15:0]         faultCode;
  reg                 alwaysBlocking;
  reg                 recoverable;
  always @*
  begin
    faultCode      = 16'h0000;
    alwaysBlocking = (progFaultKind >= `KIND_HALT_INSTR) && (progFaultKind <= `KIND_WATCHDOG);
    recoverable    = (progFaultKind >= `KIND_FRACTION) && (progFaultKind <= `KIND_FLOAT);
    case (progFaultKind)
      // RQ4: control flow codes
      `KIND_HALT_INSTR: faultCode = `CAUSE_HALT_INSTR;
      `KIND_FLOW:       faultCode = `CAUSE_FLOW;
      `KIND_CALL:       faultCode = `CAUSE_CALL_BASE | {8'h00, progFaultArg};
      `KIND_UNKNOWN_FN: faultCode = {8'h00, progFaultArg};
      // RQ5: chart codes, arg clamps to allowed range
      `KIND_CHART:
        if (progFaultArg < `CAUSE_CHART_FIRST)
          faultCode = {`CAUSE_CHART_FIRST, `CAUSE_CHART_LOW};
        else if (progFaultArg > `CAUSE_CHART_LAST)
          faultCode = {`CAUSE_CHART_LAST, `CAUSE_CHART_LOW};
        else
          faultCode = {progFaultArg, `CAUSE_CHART_LOW};
      // RQ6: checksum and watchdog
      `KIND_CHECKSUM:   faultCode = `CAUSE_CHECKSUM;
      `KIND_WATCHDOG:   faultCode = `CAUSE_WATCHDOG;
      // RQ7: arithmetic codes, recoverable unless forced
      `KIND_FRACTION, `KIND_FLOAT: faultCode = `CAUSE_FRACTION;
      `KIND_DIV_ZERO:   faultCode = `CAUSE_DIV_ZERO;
      `KIND_STRING:     faultCode = `CAUSE_STRING;
      `KIND_CAPACITY:   faultCode = `CAUSE_CAPACITY;
      `KIND_INDEX:      faultCode = `CAUSE_INDEX;
      default:          faultCode = 16'h0000;
    endcase
  end
  wire progActive = progFault && (state == ST_RUN);
  // RQ19: halt-on-fault promotes recoverable faults
  wire blocking   = progActive && (alwaysBlocking || (recoverable && haltOnFault));
  wire doInit     = coldInitReq && (state != ST_RUN);

  always @*
  begin
    next_state = state;
    case (state)
      ST_STOP:
        // RQ10: resume only on run command
        if (runReq && !coldInitReq)
          next_state = ST_RUN;
      ST_RUN:
        // RQ1: blocking fault enters halt
        if (blocking)
          next_state = ST_HALT;
      ST_HALT, ST_ERR:
        // RQ8: halt and error states left only by init, halt also by a system fault
        if (doInit)
          next_state = ST_STOP;
      default:
        next_state = ST_STOP;
    endcase
    // RQ20: system fault overrides everything except in stop mode while stopped
    if (sysFault && !(stopMode && state == ST_STOP))
      next_state = ST_ERR;
  end

  // ==========================================================
  // state, capture and flags
  integer i;
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state           <= ST_STOP;
      haltCause       <= 16'h0000;
      faultSource     <= 16'h0000;
      faultAddr       <= 32'h00000000;
      stringFault     <= 1'b0;
      arithFault      <= 1'b0;
      indexFault      <= 1'b0;
      rackHealthN     <= 8'hFF;
      moduleIoHealthN <= 1'b1;
      taskIoHealthN   <= 1'b1;
      chanFault       <= {CHANNELS{1'b0}};
      errLamp         <= 1'b0;
      ioLamp          <= 1'b0;
      runEnable       <= 1'b0;
      initPulse       <= 1'b0;
      inputRefresh    <= 1'b0;
      outputsFallback <= 1'b1;
      for (i = 0; i < CHANNELS; i = i + 1)
        chanType[i] <= 16'h0000;
    end
    else
    begin
      state           <= next_state;
      runEnable       <= (next_state == ST_RUN);
      // RQ9: init pulses refresh, fallback outputs
      initPulse       <= doInit;
      inputRefresh    <= doInit;
      outputsFallback <= (next_state != ST_RUN);
      // RQ2: error lamp follows halt
      errLamp         <= (next_state == ST_HALT);
      if (doInit)
      begin
        // RQ22: captured words cleared only here
        haltCause       <= 16'h0000;
        faultSource     <= 16'h0000;
        faultAddr       <= 32'h00000000;
        stringFault     <= 1'b0;
        arithFault      <= 1'b0;
        indexFault      <= 1'b0;
        rackHealthN     <= 8'hFF;
        moduleIoHealthN <= 1'b1;
        taskIoHealthN   <= 1'b1;
        chanFault       <= {CHANNELS{1'b0}};
        ioLamp          <= 1'b0;
      end
      else
      begin
        if (clearReq)
        begin
          stringFault <= 1'b0;
          arithFault  <= 1'b0;
          indexFault  <= 1'b0;
        end
        // RQ18: cause word updated on every program fault with a nonzero code while running
        if (progActive && faultCode != 16'h0000)
          haltCause <= faultCode;
        // RQ3: capture instruction address on halt
        if (blocking)
          faultAddr <= instrAddr;
        // RQ11: recoverable faults set flags, halt only if halt-on-fault; set beats clear
        if (progActive)
        begin
          // RQ16: string flag
          if (progFaultKind == `KIND_STRING)
            stringFault <= 1'b1;
          // RQ17: arithmetic flag
          if (progFaultKind == `KIND_CAPACITY || progFaultKind == `KIND_FLOAT
              || progFaultKind == `KIND_DIV_ZERO || progFaultKind == `KIND_FRACTION)
            arithFault <= 1'b1;
          // RQ18: index flag
          if (progFaultKind == `KIND_INDEX)
            indexFault <= 1'b1;
        end
      end
      // RQ21: fault source code; set wins over init
      if (sysFault && next_state == ST_ERR)
      begin
        case (sysFaultKind)
          `SYS_WATCHDOG:   faultSource <= `SRC_WATCHDOG_BUS;
          `SYS_BUS_WIRING: faultSource <= `SRC_BUS_WIRING;
          default:         faultSource <= `SRC_STACK_INT;
        endcase
        ioLamp <= 1'b1;
      end
      if (ioFault)
      begin
        // RQ12: module health low, lamp steady
        moduleIoHealthN <= 1'b0;
        ioLamp          <= 1'b1;
        // RQ13: task health
        if (ioFaultInTask)
          taskIoHealthN <= 1'b0;
        // RQ14: per-rack health
        rackHealthN[ioFaultRack] <= 1'b0;
        // RQ15: channel bit and type
        chanFault[ioFaultChan] <= 1'b1;
        chanType[ioFaultChan]  <= ioFaultType;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  reg         awHeld;
  reg         wHeld;
  reg  [7:0]  awAddr;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  wire        doWrite = awHeld && wHeld && !s_axi_bvalid;

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_OKAY;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 8'h00;
      wData         <= 32'h00000000;
      wStrb         <= 4'h0;
      haltOnFault   <= 1'b0;
      stopMode      <= 1'b0;
      chanSel       <= {CHAN_W{1'b0}};
      coldInitReq   <= 1'b0;
      runReq        <= 1'b0;
      clearReq      <= 1'b0;
    end
    else
    begin
      coldInitReq   <= 1'b0;
      runReq        <= 1'b0;
      clearReq      <= 1'b0;
      s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !wHeld && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (doWrite)
      begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `AXI_OKAY;
        case ({awAddr[7:2], 2'b00})
          `REG_CONTROL:
            if (wStrb[0])
            begin
              // RQ8: cold init bit self clears
              coldInitReq <= wData[`CTL_COLD_INIT];
              runReq      <= wData[`CTL_RUN];
              haltOnFault <= wData[`CTL_HALT_ON_FAULT];
              stopMode    <= wData[`CTL_STOP_MODE];
              clearReq    <= wData[`CTL_CLEAR_FLAGS];
            end
          `REG_CHAN_SELECT:
            if (wStrb[0])
              chanSel <= wData[CHAN_W-1:0];
          `REG_STATUS, `REG_HEALTH, `REG_FAULT_SOURCE, `REG_HALT_CAUSE,
          `REG_ADDR_LOW, `REG_ADDR_HIGH, `REG_CHAN_DIAG:
            s_axi_bresp <= `AXI_OKAY;
          default:
            s_axi_bresp <= `AXI_SLVERR;
        endcase
      end
    end
  end

  // read path: one read at a time, answer one cycle after address
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `AXI_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `AXI_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
          `REG_CONTROL:      s_axi_rdata <= {28'h0000000, stopMode, haltOnFault, 2'b00};
          `REG_STATUS:
            s_axi_rdata <= {25'h0000000, state == ST_STOP, indexFault, arithFault, stringFault,
                            state == ST_ERR, state == ST_HALT, state == ST_RUN};
          `REG_HEALTH:
            s_axi_rdata <= {22'h000000, taskIoHealthN, moduleIoHealthN, rackHealthN};
          `REG_FAULT_SOURCE: s_axi_rdata <= {16'h0000, faultSource};
          `REG_HALT_CAUSE:   s_axi_rdata <= {16'h0000, haltCause};
          `REG_ADDR_LOW:     s_axi_rdata <= {16'h0000, faultAddr[15:0]};
          `REG_ADDR_HIGH:    s_axi_rdata <= {16'h0000, faultAddr[31:16]};
          `REG_CHAN_SELECT:  s_axi_rdata <= {{(32-CHAN_W){1'b0}}, chanSel};
          `REG_CHAN_DIAG:    s_axi_rdata <= {15'h0000, chanFault[chanSel], chanType[chanSel]};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AXI_SLVERR;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** verification/controller_fault_diagnostics_sva.sv ***
// port assertions for the fault diagnostics block
`timescale 1ns/100ps
`default_nettype none
`include "fault_diag_consts.vh"
module controller_fault_diagnostics_sva (
  input wire logic       ref_clk,         // clock
  input wire logic       reset_n,         // async reset, low
  input wire logic       progFault,       // program fault strobe
  input wire logic [3:0] progFaultKind,   // program fault kind
  input wire logic       sysFault,        // system fault strobe
  input wire logic       ioFault,         // i/o fault strobe
  input wire logic       ioFaultInTask,   // fault in running task
  input wire logic       s_axi_arvalid,   // read address valid
  input wire logic       s_axi_arready,   // read address ready
  input wire logic       s_axi_rvalid,    // read data valid
  input wire logic       runEnable,       // running
  input wire logic       initPulse,       // init pulse
  input wire logic       inputRefresh,    // input refresh pulse
  input wire logic       outputsFallback, // fallback outputs
  input wire logic       errLamp,         // error lamp
  input wire logic       ioLamp,          // i/o lamp
  input wire logic       moduleIoHealthN, // module health, low = fault
  input wire logic       taskIoHealthN    // task health, low = fault
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // =====
  // named steps
  sequence s_block;
    progFault && runEnable && progFaultKind >= `KIND_HALT_INSTR
      && progFaultKind <= `KIND_WATCHDOG;
  endsequence
  sequence s_halt;
    errLamp && !runEnable;
  endsequence
  // =====
  // assertions
  a_block_halts: assert property (s_block |=> s_halt)
    else $error("blocking fault did not halt");
  a_halt_needs_init: assert property ($fell(errLamp) |-> initPulse || $past(initPulse))
    else $error("halt left without init");
  a_init_refresh: assert property (initPulse |-> inputRefresh ##1 !initPulse)
    else $error("init pulse malformed");
  // one cycle of slack, though the registered fallback changes on the same edge as runEnable
  a_idle_fallback: assert property (!runEnable && !$past(runEnable) |-> outputsFallback)
    else $error("outputs not in fallback while idle");
  a_run_clean: assert property ($rose(runEnable) |-> !errLamp)
    else $error("run started while halted");
  a_module_health: assert property (ioFault |=> !moduleIoHealthN && ioLamp)
    else $error("module health not cleared");
  a_task_health: assert property (ioFault && ioFaultInTask |=> !taskIoHealthN)
    else $error("task health not cleared");
  a_sys_stop: assert property (sysFault && runEnable |=> !runEnable && ioLamp)
    else $error("system fault kept running");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready not a pulse");
endmodule
bind controller_fault_diagnostics controller_fault_diagnostics_sva u_sva (
  .ref_clk, .reset_n, .progFault, .progFaultKind, .sysFault, .ioFault, .ioFaultInTask,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .runEnable, .initPulse, .inputRefresh,
  .outputsFallback, .errLamp, .ioLamp, .moduleIoHealthN, .taskIoHealthN
);
`default_nettype wire

// *** verification/tb_controller_fault_diagnostics.sv ***
// register-level bench for the fault diagnostics block
`timescale 1ns/100ps
`default_nettype none
`include "fault_diag_consts.vh"
module tb_controller_fault_diagnostics;
  logic        ref_clk = 1'b0, reset_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, progFaultArg = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, instrAddr = 32'h0, rd;
  logic [3:0]  s_axi_wstrb = 4'hF, progFaultKind = 4'h0, ioFaultChan = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, progFault = 1'b0;
  logic        sysFault = 1'b0, ioFault = 1'b0, ioFaultInTask = 1'b0;
  logic [1:0]  sysFaultKind = 2'h0, resp;
  logic [2:0]  ioFaultRack = 3'h0;
  logic [15:0] ioFaultType = 16'h0, ec;
  logic [7:0]  arg;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire         runEnable, initPulse, outputsFallback, inputRefresh;
  wire         errLamp, ioLamp, moduleIoHealthN, taskIoHealthN;
  int          failures = 0, samplesChecked = 0, inits = 0, n;
  logic [15:0] recCause [8:13] = '{16'hDE87, 16'hDEF0, 16'hDEF1, 16'hDEF2, 16'hDEF3, 16'hDE87};
  logic [2:0]  recFlag [8:13] = '{3'b010, 3'b010, 3'b001, 3'b010, 3'b100, 3'b010};

  controller_fault_diagnostics DUT (.*);

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (initPulse === 1'b1)
      inits++;

  // =====
  // bus and stimulus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // each access ends one edge after release so no signal is driven twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic ctl(input logic [31:0] d);
    wr(`REG_CONTROL, d);
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic fault(input logic [3:0] k, input logic [7:0] g);
    progFault     <= 1'b1;
    progFaultKind <= k;
    progFaultArg  <= g;
    instrAddr     <= {8'hA5, 4'h0, k, g, 8'h3C};
    @(posedge ref_clk);
    progFault <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic sys(input logic [1:0] k);
    sysFault     <= 1'b1;
    sysFaultKind <= k;
    @(posedge ref_clk);
    sysFault <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic io(input logic [2:0] r, input logic t);
    ioFault       <= 1'b1;
    ioFaultRack   <= r;
    ioFaultInTask <= t;
    ioFaultChan   <= 4'h3;
    ioFaultType   <= 16'hABCD;
    @(posedge ref_clk);
    ioFault <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // =====
  // tests
  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rdr(`REG_STATUS);
    chk(rd, 32'h40);
    rdr(`REG_HEALTH);
    chk(rd, 32'h3FF);
    rdr(8'h40);
    chk(rd, 32'h0);
    chk(resp, `AXI_SLVERR);
    wr(8'h40, 32'h0);
    chk(resp, `AXI_SLVERR);
    wr(`REG_HALT_CAUSE, 32'h1234);
    chk(resp, `AXI_OKAY);
    rdr(`REG_HALT_CAUSE);
    chk(rd, 32'h0);
    $display("test reset and access done");
    ctl(32'h2);
    for (int k = 8; k <= 13; k++)
    begin
      ctl(32'h10);
      fault(k[3:0], 8'h00);
      rdr(`REG_HALT_CAUSE);
      chk(rd, recCause[k]);
      chk(runEnable, 1'b1);
      rdr(`REG_STATUS);
      chk(rd[5:3], recFlag[k]);
    end
    $display("test recoverable faults done");
    for (int k = 1; k <= 7; k++)
    begin
      arg = (k == 5) ? 8'h95 : 8'h17 + k;
      case (k)
        1: ec = 16'h2258;
        2: ec = 16'h2259;
        3: ec = {8'h23, arg};
        4: ec = {8'h00, arg};
        5: ec = {arg, 8'hF4};
        6: ec = 16'h9690;
        default: ec = 16'hDEB0;
      endcase
      fault(k[3:0], arg);
      rdr(`REG_HALT_CAUSE);
      chk(rd, ec);
      rdr(`REG_ADDR_LOW);
      chk(rd, {arg, 8'h3C});
      rdr(`REG_ADDR_HIGH);
      chk(rd, {8'hA5, 4'h0, k[3:0]});
      rdr(`REG_STATUS);
      chk({errLamp, rd[2:0]}, 4'b1010);
      fault(4'h1, 8'h00);
      ctl(32'h2);
      rdr(`REG_HALT_CAUSE);
      chk(runEnable, 1'b0);
      chk(rd, {16'h0, ec});
      n = inits;
      ctl(32'h1);
      rdr(`REG_HALT_CAUSE);
      chk(runEnable, 1'b0);
      chk(inits - n, 32'd1);
      chk(rd, 32'h0);
      ctl(32'h2);
    end
    $display("test blocking faults done");
    ctl(32'h4);
    fault(4'hC, 8'h00);
    rdr(`REG_STATUS);
    chk({rd[5], rd[1], runEnable}, 3'b110);
    rdr(`REG_HALT_CAUSE);
    chk(rd, 32'hDEF3);
    ctl(32'h1);
    ctl(32'h2);
    io(3'h5, 1'b1);
    io(3'h0, 1'b0);
    rdr(`REG_HEALTH);
    chk({ioLamp, runEnable}, 2'b11);
    chk(rd, 32'h0DE);
    wr(`REG_CHAN_SELECT, 32'h3);
    rdr(`REG_CHAN_DIAG);
    chk(rd, 32'h1ABCD);
    $display("test io faults done");
    for (int s = 0; s <= 3; s++)
    begin
      sys(s[1:0]);
      ctl(32'h2);
      rdr(`REG_STATUS);
      chk({runEnable, rd[2]}, 2'b01);
      rdr(`REG_FAULT_SOURCE);
      chk(rd, (s == 0) ? 32'h80 : (s == 1) ? 32'h81 : 32'h90);
      ctl(32'h1);
      ctl(32'h2);
    end
    sys(2'h1);
    ctl(32'h9);
    sys(2'h0);
    rdr(`REG_STATUS);
    chk({rd[6], rd[2]}, 2'b10);
    rdr(`REG_FAULT_SOURCE);
    chk(rd, 32'h0);
    $display("test system faults done");
    finish_test;
  end
  initial
  begin
    #200000;
    failures++;
    finish_test;
  end
endmodule
`default_nettype wire
